// ==== hdl/ibrs_pkg.sv ====
package ibrs_pkg;
  // ==========================================================
  // command opcodes
  localparam logic [7:0] OP_BYTE_IN   = 8'h20;
  localparam logic [7:0] OP_BITS_OUT  = 8'h13;
  localparam logic [7:0] OP_PIN_WRITE = 8'h80;
  localparam logic [7:0] OP_SEND_NOW  = 8'h87;
  // ==========================================================
  // pin positions and reset values
  localparam int         PIN_SCL      = 0;
  localparam int         PIN_DOUT     = 1;
  localparam int         PIN_DIN      = 2;
  localparam logic [7:0] PIN_VAL_RST  = 8'hFF;
  localparam logic [7:0] PIN_DIR_RST  = 8'h00;
  // ==========================================================
  // timing
  localparam int CLK_MHZ        = 125;
  localparam int HALF_BIT_NS    = 2_500;
  localparam int HALF_BIT_CYC   = (HALF_BIT_NS * CLK_MHZ) / 1_000;
  localparam int LATENCY_MS     = 16;
  localparam int LATENCY_CYC    = LATENCY_MS * 1_000 * CLK_MHZ;
  localparam int RET_DEPTH      = 4;
  // ==========================================================
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ibrs_byte_t;
endpackage : ibrs_pkg

// ==== hdl/ibrs_sequencer.sv ====
module ibrs_sequencer #(
  parameter int LATENCY_CYCLES = ibrs_pkg::LATENCY_CYC
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  // host command stream
  input  wire ibrs_pkg::ibrs_byte_t cmd_in,
  output logic                   cmd_ready_out,
  // return stream to host
  output ibrs_pkg::ibrs_byte_t   ret_out,
  input  wire logic              ret_ready_in,
  // low gpio port
  output logic [7:0]             low_gpio_port_out,
  output logic [7:0]             low_gpio_port_oe_out,
  input  wire logic [7:0]        low_gpio_port_in
);
  import ibrs_pkg::*;

  typedef enum {
    S_OP, S_LEN0, S_LEN1, S_BCNT, S_BVAL, S_PVAL, S_PDIR,
    S_SHIFT_IN, S_SHIFT_OUT
  } ibrs_state_t;

  ibrs_state_t state_q;
  logic [15:0] len_q;
  logic [7:0]  sh_q, pval_q, pdir_q, bits_q;
  logic [2:0]  bit_q;
  logic [15:0] half_q;
  logic        phase_q;
  logic [1:0]  din_sync_q;
  logic [7:0]  ret_mem_q [RET_DEPTH];
  logic [1:0]  wr_q, rd_q;
  logic [2:0]  cnt_q;
  logic        flush_q;
  logic [31:0] lat_q;
  logic        push;
  logic        stall;
  logic        hold;
  logic        tick;

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = p + 2'd1;
  endfunction : ptr_inc

  // ==========================================================
  // synchroniser for data input pin
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) din_sync_q <= 2'b00;
    else din_sync_q <= {din_sync_q[0], low_gpio_port_in[PIN_DIN]};
  end

  // half-bit timer, slow rate as one-cycle enable; it parks at its
  // last count while a full return buffer would lose the next byte
  assign hold = (state_q == S_SHIFT_IN) && stall;
  assign tick = (half_q == 16'(HALF_BIT_CYC - 1)) && !hold;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !(state_q == S_SHIFT_IN || state_q == S_SHIFT_OUT) || tick)
      half_q <= 16'h0000;
    else if (half_q != 16'(HALF_BIT_CYC - 1)) half_q <= half_q + 16'h0001;
  end

  // stall byte intake while return buffer is full; no drop
  assign stall = (cnt_q == 3'(RET_DEPTH));
  assign push  = (state_q == S_SHIFT_IN) && tick && phase_q &&
                 (bit_q == 3'd7);
  always_ff @(posedge ref_clk_in) cmd_ready_out <= !rst_in && !stall &&
    (state_q != S_SHIFT_IN) && (state_q != S_SHIFT_OUT) &&
    !(cmd_in.valid && cmd_ready_out);

  // ==========================================================
  // command decode and bit engine, strictly sequential
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= S_OP;
      len_q   <= 16'h0000;
      sh_q    <= 8'h00;
      bits_q  <= 8'h00;
      bit_q   <= 3'd0;
      phase_q <= 1'b0;
      pval_q  <= PIN_VAL_RST;
      pdir_q  <= PIN_DIR_RST;
    end else begin
      case (state_q)
        S_OP: if (cmd_in.valid && cmd_ready_out) begin
          case (cmd_in.data)
            OP_BYTE_IN:   state_q <= S_LEN0;
            OP_BITS_OUT:  state_q <= S_BCNT;
            OP_PIN_WRITE: state_q <= S_PVAL;
            default:      state_q <= S_OP;
          endcase
        end
        S_LEN0: if (cmd_in.valid && cmd_ready_out) begin
          len_q[7:0] <= cmd_in.data;
          state_q <= S_LEN1;
        end
        S_LEN1: if (cmd_in.valid && cmd_ready_out) begin
          len_q[15:8] <= cmd_in.data;
          bit_q <= 3'd0;
          phase_q <= 1'b0;
          state_q <= S_SHIFT_IN;
        end
        S_BCNT: if (cmd_in.valid && cmd_ready_out) begin
          bits_q <= cmd_in.data;
          state_q <= S_BVAL;
        end
        S_BVAL: if (cmd_in.valid && cmd_ready_out) begin
          sh_q <= cmd_in.data;
          bit_q <= 3'd0;
          phase_q <= 1'b0;
          state_q <= S_SHIFT_OUT;
        end
        S_PVAL: if (cmd_in.valid && cmd_ready_out) begin
          pval_q <= cmd_in.data;
          state_q <= S_PDIR;
        end
        S_PDIR: if (cmd_in.valid && cmd_ready_out) begin
          pdir_q <= cmd_in.data;
          state_q <= S_OP;
        end
        S_SHIFT_IN: if (tick) begin
          phase_q <= !phase_q;
          if (!phase_q) pval_q[PIN_SCL] <= 1'b1; // rising: sample
          else pval_q[PIN_SCL] <= 1'b0;
          if (!phase_q) sh_q <= {sh_q[6:0], din_sync_q[1]};
          if (phase_q) begin
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              if (len_q == 16'h0000) state_q <= S_OP;
              else len_q <= len_q - 16'h0001;
            end
          end
        end
        S_SHIFT_OUT: if (tick) begin
          phase_q <= !phase_q;
          if (!phase_q) begin
            pval_q[PIN_SCL]  <= 1'b0; // falling: drive
            pval_q[PIN_DOUT] <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
          end else begin
            pval_q[PIN_SCL] <= 1'b1;
            bits_q <= bits_q - 8'h01;
            if (bits_q == 8'h00) state_q <= S_OP;
          end
        end
        default: state_q <= S_OP;
      endcase
    end
  end

  // pins: direction one drives, input pin value ignored
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      low_gpio_port_out    <= PIN_VAL_RST & PIN_DIR_RST; // no value on inputs
      low_gpio_port_oe_out <= PIN_DIR_RST;
    end else begin
      low_gpio_port_out    <= pval_q & pdir_q;
      low_gpio_port_oe_out <= pdir_q;
    end
  end

  // ==========================================================
  // return buffer of received bytes
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) wr_q <= 2'd0;
    else if (push) begin
      ret_mem_q[wr_q] <= sh_q;
      wr_q <= ptr_inc(wr_q);
    end
  end

  // flush on send-now or latency expiry; held until drained
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      flush_q <= 1'b0;
      lat_q   <= 32'h0000_0000;
    end else begin
      if (cnt_q == 3'd0) lat_q <= 32'h0000_0000;
      else if (lat_q != 32'(LATENCY_CYCLES)) lat_q <= lat_q + 32'h0000_0001;
      if (state_q == S_OP && cmd_in.valid && cmd_ready_out &&
          cmd_in.data == OP_SEND_NOW)
        flush_q <= 1'b1;
      else if (lat_q == 32'(LATENCY_CYCLES) - 32'h0000_0001)
        flush_q <= 1'b1;
      else if (cnt_q == 3'd0) flush_q <= 1'b0;
    end
  end

  logic pop;
  assign pop = ret_out.valid && ret_ready_in;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_q  <= 2'd0;
      cnt_q <= 3'd0;
      ret_out <= '0;
    end else begin
      if (pop) rd_q <= ptr_inc(rd_q);
      cnt_q <= cnt_q + 3'(push) - 3'(pop);
      ret_out.valid <= flush_q && (cnt_q > 3'(pop));
      ret_out.data  <= pop ? ret_mem_q[ptr_inc(rd_q)] : ret_mem_q[rd_q];
    end
  end

  // ==========================================================
  a_send_now_flush: assert property (@(posedge ref_clk_in) disable iff
    (rst_in) (state_q == S_OP && cmd_in.valid && cmd_ready_out &&
    cmd_in.data == OP_SEND_NOW && cnt_q != 3'd0) |=> flush_q)
    else $error("send-now did not raise flush");
  a_pin_mask: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ((low_gpio_port_out & ~low_gpio_port_oe_out) == 8'h00))
    else $error("value driven on input pin");
  a_dir_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_q == S_PDIR && cmd_in.valid && cmd_ready_out) |=> ##1
    (low_gpio_port_oe_out == $past(cmd_in.data, 2)))
    else $error("direction not applied");
  a_push_once: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    push |=> !push)
    else $error("double byte push");
  a_no_intake: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_q == S_SHIFT_IN) |-> !cmd_ready_out)
    else $error("command taken mid shift");
  a_len_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (push && len_q == 16'h0000) |=> state_q == S_OP)
    else $error("byte count overrun");
  a_bit_msb: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_q == S_SHIFT_OUT && tick && !phase_q) |=>
    pval_q[PIN_DOUT] == $past(sh_q[7]))
    else $error("bit out not msb");
  a_rise_sample: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_q == S_SHIFT_IN && tick && !phase_q) |=> pval_q[PIN_SCL])
    else $error("sample not on rising scl");
endmodule : ibrs_sequencer

// ==== test/ibrs_i2c_slave.sv ====
module ibrs_i2c_slave #(
  parameter logic [7:0] FIRST_BYTE = 8'hA5
) (
  // reset and bus wires
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  // open-drain pull and last ack level seen
  output logic      sda_low_out,
  output logic      ack_bit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // burst read slave
  logic [7:0] cur_q;
  logic [3:0] idx_q;
  logic       stop_q;
  // master samples on the rise, so step to the next bit there
  always @(posedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      idx_q       <= 4'h0;
      stop_q      <= 1'b0;
      cur_q       <= FIRST_BYTE;
      ack_bit_out <= 1'b0;
    end else if (idx_q == 4'h8) begin
      idx_q       <= 4'h0;
      ack_bit_out <= sda_in;
      stop_q      <= stop_q | sda_in;
      cur_q       <= cur_q + 8'h01;
    end else begin
      idx_q <= idx_q + 4'h1;
    end
  end
  // data moves only while scl is low; released in the ack slot
  always @(negedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      sda_low_out <= 1'b0;
    end else begin
      sda_low_out <= !stop_q && (idx_q < 4'h8) &&
                     !cur_q[3'h7 - idx_q[2:0]];
    end
  end
endmodule : ibrs_i2c_slave

// ==== test/ibrs_sequencer_test.sv ====
module ibrs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ibrs_pkg::*;
  // ==========================================================
  // bench signals
  localparam int         LAT   = 200;
  localparam logic [7:0] FIRST = 8'hA5;
  logic       ref_clk_in, rst_in, ret_ready_in, cmd_ready_out;
  ibrs_byte_t cmd_in, ret_out;
  logic [7:0] pin_q, oe_q, pins_in;
  logic       scl, sda, slave_low, ack_bit;
  int         fail_count = 0;
  int         comparisons = 0;
  // open-drain wires, pulled up unless someone pulls low
  assign scl = !(oe_q[PIN_SCL] && !pin_q[PIN_SCL]);
  assign sda = !((oe_q[PIN_DOUT] && !pin_q[PIN_DOUT]) || slave_low);
  assign pins_in = {5'h1F, sda, sda, scl};
  ibrs_sequencer #(.LATENCY_CYCLES(LAT)) ibrs_sequencer_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .ret_out(ret_out),
    .ret_ready_in(ret_ready_in), .low_gpio_port_out(pin_q),
    .low_gpio_port_oe_out(oe_q), .low_gpio_port_in(pins_in));
  ibrs_i2c_slave #(.FIRST_BYTE(FIRST)) ibrs_i2c_slave_i (
    .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_low_out(slave_low), .ack_bit_out(ack_bit));
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // a wait that ran out is a failure, not a hang
  task automatic limit(input int n);
    if (n > 20000) begin
      fail_count++;
      results();
    end
  endtask : limit
  task automatic send(input logic [7:0] b[$]);
    int n;
    foreach (b[k]) begin
      cmd_in <= '{valid: 1'b1, data: b[k]};
      for (n = 0; n <= 20000; n++) begin
        @(posedge ref_clk_in);
        if (cmd_ready_out === 1'b1) break;
      end
      limit(n);
    end
    cmd_in <= '0;
    @(posedge ref_clk_in);
  endtask : send
  // drain stays enabled afterwards, so back-to-back gets never clash
  task automatic get(output logic [7:0] d, output int n);
    ret_ready_in <= 1'b1;
    for (n = 0; n <= 20000; n++) begin
      @(posedge ref_clk_in);
      if (ret_out.valid === 1'b1) break;
    end
    limit(n);
    d = ret_out.data;
  endtask : get
  // ==========================================================
  // scenarios
  task automatic t_pins;
    send('{OP_PIN_WRITE, 8'hFF, 8'hFB});
    repeat (4) @(posedge ref_clk_in);
    check("pins", pin_q, 8'hFB);
    check("dir", oe_q, 8'hFB);
    send('{OP_PIN_WRITE, 8'hFE, 8'hFB});
    repeat (4) @(posedge ref_clk_in);
    check("pins", pin_q, 8'hFA);
    check("lines", {6'h00, sda, scl}, 8'h02);
  endtask : t_pins
  // ack values differ in low bits, so a wrong bit order stops the burst
  task automatic t_burst;
    logic [7:0] d;
    int         n;
    for (int i = 0; i < 3; i++) begin
      send('{OP_BYTE_IN, 8'h00, 8'h00, OP_BITS_OUT, 8'h00,
             (i == 2) ? 8'hFF : ((i == 0) ? 8'h7F : 8'h00),
             OP_PIN_WRITE, 8'hFE, 8'hFB});
      check("ack", {7'h00, ack_bit}, (i == 2) ? 8'h01 : 8'h00);
    end
    send('{OP_SEND_NOW});
    for (int j = 0; j < 3; j++) begin
      get(d, n);
      check("data", d, 8'(FIRST + j));
    end
    repeat (LAT * 2) @(posedge ref_clk_in);
    check("extra", {7'h00, ret_out.valid}, 8'h00);
  endtask : t_burst
  task automatic t_timed(input logic flush);
    logic [7:0] d;
    int         n;
    send('{OP_BYTE_IN, 8'h00, 8'h00});
    if (flush) send('{OP_SEND_NOW});
    else send('{OP_PIN_WRITE, 8'hFE, 8'hFB});
    get(d, n);
    check("stopped", d, 8'hFF);
    if (flush) check("flush", 8'(n < LAT / 2), 8'h01);
    else check("timer", 8'(n > LAT / 2), 8'h01);
    // single read closes with a nak bit, then scl held low and sda released
    send('{OP_BITS_OUT, 8'h00, 8'hFF, OP_PIN_WRITE, 8'hFE, 8'hFB});
    check("nak", {7'h00, ack_bit}, 8'h01);
  endtask : t_timed
  // free-running bench clock
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // main sequence
  initial begin
    rst_in = 1'b1;
    cmd_in = '0;
    ret_ready_in = 1'b0;
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    check("rst oe", oe_q, 8'h00);
    check("rst pins", pin_q, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    t_pins();
    t_burst();
    t_timed(1'b1);
    t_timed(1'b0);
    results();
  end
endmodule : ibrs_sequencer_test
